//--- verilog/mcb_config_bank.sv
// Configuration register bank of the three-phase metering core
//
// Our own choice: strobed register access.
`timescale 1ns/100ps

// Summary of operation
// - A channel bit of 1 powers that analog channel down; 0 keeps it active.
// - Power-down register is 11 bits: 10..8 voltage C,B,A; 5..2 current N,A,B,C.
// - Mode one bit 22: fast RMS through high-pass when 1, bypass when 0.
// - Mode one bit 23: waveform from normal RMS channel at 0, fast at 1.
// - Each RMS source field: 00 high-pass, 01 fundamental, 11 sinc; resets 00.
// - Source fields: IC 3:2, IB 5:4, IA 7:6, IN 9:8, VA 15:14, VB 17:16, VC 19:18.
// - Mode two bit 22 sets RMS refresh period: 1 gives 1000ms, 0 gives 500ms.
// - Mode two bit 23 sets mains frequency: 1 is 60Hz, 0 is 50Hz.
// - Mode three bit 4: sum threshold against neutral RMS at 0, summed waveform at 1.
// - Mode three bits 6:5 pick period phase: 00 A, 01 B, 10 C, 11 A.
// - Mode three bit 7: apparent power as RMS product at 0, vector magnitude at 1.
// - Mode three bit 8: combined power totals absolute at 0, signed at 1.
// - Mode three bit 9 holds both pulse outputs off at 0, allows them at 1.
// - Pulse source 0000/1111 off; 0001-0011 phase energy; 0100/1101 combined energy.
// - Codes 0101-1100 select positive/negative phase or combined sources; 1110 apparent.
// - Mode three bit 15: energy added absolute at 0, algebraic at 1.
// - Mode three bit 16: reactive energy fundamental at 0, full wave at 1.
// - Mode three bit 17: active power full wave at 0, fundamental at 1.
module mcb_config_bank
	import mcb_pkg::*;
#(
	parameter int unsigned REFRESH_CYC_SHORT = REFRESH_CYC_S,
	parameter int unsigned REFRESH_CYC_LONG  = REFRESH_CYC_L
) (
	// Clock and reset
	input  wire logic           sys_clk,
	input  wire logic           rst,
	// Register port
	input  wire mcb_bus_req_t   bus_req,
	output logic [DATA_W-1:0]   rd_data,
	// Analog front end
	output mcb_chan_pd_t        chan_pd,
	// Metering datapath configuration
	output mcb_rms_src_t        rms_src,
	output mcb_calc_cfg_t       calc_cfg,
	output mcb_pulse_cfg_t      pulse_cfg,
	output logic                rms_refresh_tick,
	// Energy pulses
	input  wire logic           energy_raw_first,
	input  wire logic           energy_raw_second,
	output logic                energy_pulse_first,
	output logic                energy_pulse_second
);

	// Decodes a two-bit RMS source field; 10 is undefined and falls back to high-pass
	function automatic mcb_rms_path_t mcb_rms_path(input logic [1:0] code);
		mcb_rms_path_t path;
		path = MCB_RMS_HPF;
		case (code)
			2'h1: path = MCB_RMS_FUND;
			2'h3: path = MCB_RMS_SINC;
			default: path = MCB_RMS_HPF;
		endcase
		return path;
	endfunction : mcb_rms_path

	// Storage
	logic [PD_W-1:0]          chan_pd_reg;
	logic [DATA_W-1:0]        operating_config_one;
	logic [DATA_W-1:0]        operating_config_two;
	logic [DATA_W-1:0]        operating_config_three;
	logic [REFRESH_CNT_W-1:0] refresh_cnt;
	logic [7:0]               refresh_ticks;

	// Address decode
	wire                      hit_pd;
	wire                      hit_m1;
	wire                      hit_m2;
	wire                      hit_m3;
	wire                      hit_st;
	wire                      wr_pd;
	wire                      wr_m1;
	wire                      wr_m2;
	wire                      wr_m3;

	assign hit_pd = (bus_req.addr == OFS_CHAN_PD);
	assign hit_m1 = (bus_req.addr == OFS_OPERATING_CONFIG_ONE);
	assign hit_m2 = (bus_req.addr == OFS_OPERATING_CONFIG_TWO);
	assign hit_m3 = (bus_req.addr == OFS_OPERATING_CONFIG_THREE);
	assign hit_st = (bus_req.addr == OFS_STATUS);
	assign wr_pd  = bus_req.wr & hit_pd;
	assign wr_m1  = bus_req.wr & hit_m1;
	assign wr_m2  = bus_req.wr & hit_m2;
	assign wr_m3  = bus_req.wr & hit_m3;

	// Register writes; mode registers keep only their implemented bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chan_pd_reg <= CHAN_PD_RST;
			operating_config_one       <= MODE_RST;
			operating_config_two       <= MODE_RST;
			operating_config_three       <= MODE_RST;
		end else begin
			if (wr_pd)
				chan_pd_reg <= bus_req.wdata[PD_W-1:0];
			if (wr_m1)
				operating_config_one <= bus_req.wdata & OPERATING_CONFIG_ONE_MASK;
			if (wr_m2)
				operating_config_two <= bus_req.wdata & OPERATING_CONFIG_TWO_MASK;
			if (wr_m3)
				operating_config_three <= bus_req.wdata & OPERATING_CONFIG_THREE_MASK;
		end
	end

	// Channel power-down controls
	assign chan_pd.va = chan_pd_reg[PD_VA];
	assign chan_pd.vb = chan_pd_reg[PD_VB];
	assign chan_pd.vc = chan_pd_reg[PD_VC];
	assign chan_pd.ia = chan_pd_reg[PD_IA];
	assign chan_pd.ib = chan_pd_reg[PD_IB];
	assign chan_pd.ic = chan_pd_reg[PD_IC];
	assign chan_pd.in = chan_pd_reg[PD_IN];

	// RMS input path per channel
	assign rms_src.ic = mcb_rms_path(operating_config_two[M2_SRC_IC +: 2]);
	assign rms_src.ib = mcb_rms_path(operating_config_two[M2_SRC_IB +: 2]);
	assign rms_src.ia = mcb_rms_path(operating_config_two[M2_SRC_IA +: 2]);
	assign rms_src.in = mcb_rms_path(operating_config_two[M2_SRC_IN +: 2]);
	assign rms_src.va = mcb_rms_path(operating_config_two[M2_SRC_VA +: 2]);
	assign rms_src.vb = mcb_rms_path(operating_config_two[M2_SRC_VB +: 2]);
	assign rms_src.vc = mcb_rms_path(operating_config_two[M2_SRC_VC +: 2]);

	// Period phase: code 11 folds back onto phase A
	wire [1:0]   period_code;
	mcb_phase_t  period_phase;

	assign period_code  = operating_config_three[M3_PERIOD_LO +: 2];
	assign period_phase = (period_code == 2'h1) ? MCB_PH_B :
	                      (period_code == 2'h2) ? MCB_PH_C : MCB_PH_A;

	// Computation options
	assign calc_cfg.fast_hpf        = operating_config_one[M1_FAST_HPF];
	assign calc_cfg.wave_fast       = operating_config_one[M1_WAVE_FAST];
	assign calc_cfg.long_refresh    = operating_config_two[M2_LONG_REF];
	assign calc_cfg.mains_60        = operating_config_two[M2_MAINS_60];
	assign calc_cfg.isum_vs_sum     = operating_config_three[M3_ISUM_SEL];
	assign calc_cfg.period_phase    = period_phase;
	assign calc_cfg.va_vector       = operating_config_three[M3_VA_ALG];
	assign calc_cfg.power_algebraic = operating_config_three[M3_PWR_ALG];

	// Pulse source decode
	wire [3:0]        pulse_code;
	mcb_pulse_kind_t  pulse_kind;
	mcb_phase_t       pulse_phase;

	assign pulse_code = operating_config_three[M3_SRC_LO +: 4];

	always_comb begin
		pulse_kind  = MCB_PS_OFF;
		pulse_phase = MCB_PH_A;
		case (pulse_code)
			4'h1, 4'h2, 4'h3: begin
				pulse_kind  = MCB_PS_PH_ACT_REACT;
				pulse_phase = mcb_phase_t'(pulse_code[1:0] - 2'h1);
			end
			4'h4, 4'hd: begin
				pulse_kind  = MCB_PS_SUM_ACT_REACT;
			end
			4'h5, 4'h6, 4'h7: begin
				pulse_kind  = MCB_PS_PH_POS_QUAD;
				pulse_phase = mcb_phase_t'(pulse_code[1:0] - 2'h1);
			end
			4'h8: begin
				pulse_kind  = MCB_PS_SUM_POS_Q4;
			end
			4'h9, 4'ha, 4'hb: begin
				pulse_kind  = MCB_PS_PH_NEG_APP;
				pulse_phase = mcb_phase_t'(pulse_code[1:0] - 2'h1);
			end
			4'hc: begin
				pulse_kind  = MCB_PS_SUM_NEG_APP;
			end
			4'he: begin
				pulse_kind  = MCB_PS_APPARENT;
			end
			default: begin
				pulse_kind  = MCB_PS_OFF;
				pulse_phase = MCB_PH_A;
			end
		endcase
	end

	assign pulse_cfg.gate             = operating_config_three[M3_GATE];
	assign pulse_cfg.kind             = pulse_kind;
	assign pulse_cfg.phase            = pulse_phase;
	assign pulse_cfg.energy_algebraic = operating_config_three[M3_NRG_ALG];
	assign pulse_cfg.react_full       = operating_config_three[M3_VAR_FULL];
	assign pulse_cfg.act_fund         = operating_config_three[M3_WATT_FUND];

	// Pulse outputs: apparent-only source drives the second output alone
	wire first_live;
	wire second_live;
	wire next_pulse_first;
	wire next_pulse_second;

	assign first_live  = operating_config_three[M3_GATE] & (pulse_kind != MCB_PS_OFF) &
	                     (pulse_kind != MCB_PS_APPARENT);
	assign second_live = operating_config_three[M3_GATE] & (pulse_kind != MCB_PS_OFF);
	assign next_pulse_first  = first_live & energy_raw_first;
	assign next_pulse_second = second_live & energy_raw_second;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			energy_pulse_first  <= 1'b0;
			energy_pulse_second <= 1'b0;
		end else begin
			energy_pulse_first  <= next_pulse_first;
			energy_pulse_second <= next_pulse_second;
		end
	end

	// RMS refresh timer
	// Restarts when a write changes the period bit, so the first tick after a
	// change never comes from a half-used old interval.
	wire                      period_change;
	wire [REFRESH_CNT_W-1:0]  refresh_last;
	wire                      refresh_done;
	wire [REFRESH_CNT_W-1:0]  next_refresh_cnt;

	assign period_change = wr_m2 & (bus_req.wdata[M2_LONG_REF] != operating_config_two[M2_LONG_REF]);
	assign refresh_last  = operating_config_two[M2_LONG_REF] ?
	                       REFRESH_CNT_W'(REFRESH_CYC_LONG - 1) :
	                       REFRESH_CNT_W'(REFRESH_CYC_SHORT - 1);
	assign refresh_done  = (refresh_cnt >= refresh_last);
	assign next_refresh_cnt = (period_change | refresh_done) ? '0 :
	                          refresh_cnt + REFRESH_CNT_W'(1);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			refresh_cnt      <= '0;
			rms_refresh_tick <= 1'b0;
			refresh_ticks    <= 8'h00;
		end else begin
			refresh_cnt      <= next_refresh_cnt;
			rms_refresh_tick <= refresh_done & ~period_change;
			if (refresh_done & ~period_change)
				refresh_ticks <= refresh_ticks + 8'h01;
		end
	end

	// Read path: data stand only in the cycle after the read strobe
	wire [DATA_W-1:0] status_word;
	wire [DATA_W-1:0] rd_mux;
	wire [DATA_W-1:0] next_rd_data;

	assign status_word = {14'h0000, second_live, first_live, refresh_ticks};
	assign rd_mux = hit_pd ? {13'h0000, chan_pd_reg} :
	                hit_m1 ? operating_config_one :
	                hit_m2 ? operating_config_two :
	                hit_m3 ? operating_config_three :
	                hit_st ? status_word : 24'h000000;
	assign next_rd_data = bus_req.rd ? rd_mux : 24'h000000;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rd_data <= 24'h000000;
		else
			rd_data <= next_rd_data;
	end

	// Reserved power-down bits are stored as written so the host setup
	// value (ones) reads back; they steer nothing here.
	wire unused_pd_reserved;

	assign unused_pd_reserved = ^{chan_pd_reg[7:6], chan_pd_reg[1:0]};

endmodule : mcb_config_bank

//--- verilog/mcb_pkg.sv
// Package: register map, field layout, timing and carrier types of the metering config bank
package mcb_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 24;
	localparam int PD_W   = 11;

	// Register offsets
	localparam logic [7:0] OFS_CHAN_PD = 8'h93;
	localparam logic [7:0] OFS_OPERATING_CONFIG_ONE   = 8'h96;
	localparam logic [7:0] OFS_OPERATING_CONFIG_TWO   = 8'h97;
	localparam logic [7:0] OFS_OPERATING_CONFIG_THREE   = 8'h98;
	localparam logic [7:0] OFS_STATUS  = 8'h99;

	// Reset values
	localparam logic [10:0] CHAN_PD_RST = 11'h000;
	localparam logic [23:0] MODE_RST    = 24'h000000;

	// Implemented bits of the mode registers; the rest read as zero
	localparam logic [23:0] OPERATING_CONFIG_ONE_MASK = 24'hc00000;
	localparam logic [23:0] OPERATING_CONFIG_TWO_MASK = 24'hcfc3fc;
	localparam logic [23:0] OPERATING_CONFIG_THREE_MASK = 24'h03bff0;

	// Channel power-down positions
	localparam int PD_VC = 10;
	localparam int PD_VB = 9;
	localparam int PD_VA = 8;
	localparam int PD_IN = 5;
	localparam int PD_IA = 4;
	localparam int PD_IB = 3;
	localparam int PD_IC = 2;

	// Mode 1 fields
	localparam int M1_FAST_HPF  = 22;
	localparam int M1_WAVE_FAST = 23;

	// Mode 2 fields (low bit of each two-bit source field)
	localparam int M2_SRC_IC   = 2;
	localparam int M2_SRC_IB   = 4;
	localparam int M2_SRC_IA   = 6;
	localparam int M2_SRC_IN   = 8;
	localparam int M2_SRC_VA   = 14;
	localparam int M2_SRC_VB   = 16;
	localparam int M2_SRC_VC   = 18;
	localparam int M2_LONG_REF = 22;
	localparam int M2_MAINS_60 = 23;

	// Mode 3 fields
	localparam int M3_ISUM_SEL  = 4;
	localparam int M3_PERIOD_LO = 5;
	localparam int M3_VA_ALG    = 7;
	localparam int M3_PWR_ALG   = 8;
	localparam int M3_GATE      = 9;
	localparam int M3_SRC_LO    = 10;
	localparam int M3_NRG_ALG   = 15;
	localparam int M3_VAR_FULL  = 16;
	localparam int M3_WATT_FUND = 17;

	// Refresh timing
	localparam int CLK_HZ         = 250_000_000;
	localparam int REFRESH_MS_S   = 500;
	localparam int REFRESH_MS_L   = 1000;
	localparam int REFRESH_CYC_S  = REFRESH_MS_S * (CLK_HZ / 1000);
	localparam int REFRESH_CYC_L  = REFRESH_MS_L * (CLK_HZ / 1000);
	localparam int REFRESH_CNT_W  = 28;

	typedef struct packed {
		logic [7:0]  addr;
		logic [23:0] wdata;
		logic        wr;
		logic        rd;
	} mcb_bus_req_t;

	typedef enum logic [1:0] {MCB_RMS_HPF, MCB_RMS_FUND, MCB_RMS_SINC} mcb_rms_path_t;
	typedef enum logic [1:0] {MCB_PH_A, MCB_PH_B, MCB_PH_C} mcb_phase_t;
	typedef enum logic [2:0] {
		MCB_PS_OFF, MCB_PS_PH_ACT_REACT, MCB_PS_SUM_ACT_REACT, MCB_PS_PH_POS_QUAD,
		MCB_PS_SUM_POS_Q4, MCB_PS_PH_NEG_APP, MCB_PS_SUM_NEG_APP, MCB_PS_APPARENT
	} mcb_pulse_kind_t;

	typedef struct packed {
		logic va, vb, vc, ia, ib, ic, in;
	} mcb_chan_pd_t;

	typedef struct packed {
		mcb_rms_path_t ia, ib, ic, in, va, vb, vc;
	} mcb_rms_src_t;

	typedef struct packed {
		logic       fast_hpf;
		logic       wave_fast;
		logic       long_refresh;
		logic       mains_60;
		logic       isum_vs_sum;
		mcb_phase_t period_phase;
		logic       va_vector;
		logic       power_algebraic;
	} mcb_calc_cfg_t;

	typedef struct packed {
		logic            gate;
		mcb_pulse_kind_t kind;
		mcb_phase_t      phase;
		logic            energy_algebraic;
		logic            react_full;
		logic            act_fund;
	} mcb_pulse_cfg_t;
endpackage : mcb_pkg

//--- verif/mcb_config_bank_properties.sv
// Checker: decode and timing properties of the metering config bank ports
`timescale 1ns/100ps
module mcb_config_bank_properties
	import mcb_pkg::*;
#(
	parameter int unsigned REFRESH_CYC_SHORT = 20,
	parameter int unsigned REFRESH_CYC_LONG  = 40
) (
	// Clock and reset
	input  wire logic           sys_clk,
	input  wire logic           rst,
	// Register port
	input  wire mcb_bus_req_t   bus_req,
	input  wire logic [23:0]    rd_data,
	// Configuration outputs
	input  wire mcb_chan_pd_t   chan_pd,
	input  wire mcb_rms_src_t   rms_src,
	input  wire mcb_calc_cfg_t  calc_cfg,
	input  wire mcb_pulse_cfg_t pulse_cfg,
	input  wire logic           rms_refresh_tick,
	// Energy pulses
	input  wire logic           energy_raw_first,
	input  wire logic           energy_raw_second,
	input  wire logic           energy_pulse_first,
	input  wire logic           energy_pulse_second
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	wire w_pd = bus_req.wr && bus_req.addr == OFS_CHAN_PD;
	wire w_m1 = bus_req.wr && bus_req.addr == OFS_OPERATING_CONFIG_ONE;
	wire w_m2 = bus_req.wr && bus_req.addr == OFS_OPERATING_CONFIG_TWO;
	wire w_m3 = bus_req.wr && bus_req.addr == OFS_OPERATING_CONFIG_THREE;
	wire r_un = bus_req.rd && !(bus_req.addr inside {8'h93, 8'h96, 8'h97, 8'h98, 8'h99});
	logic [23:0] wd_q;

	// Last write data, so consequents need no deep sampled history
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) wd_q <= 24'h0;
		else wd_q <= bus_req.wdata;
	end

	property p_pd;
		w_pd |=> chan_pd == {wd_q[8], wd_q[9], wd_q[10], wd_q[4], wd_q[3], wd_q[2], wd_q[5]};
	endproperty
	a_pd: assert property (p_pd) else $error("power-down decode wrong");
	property p_m1;
		w_m1 |=> {calc_cfg.wave_fast, calc_cfg.fast_hpf} == wd_q[23:22];
	endproperty
	a_m1: assert property (p_m1) else $error("mode one decode wrong");
	property p_m2;
		w_m2 |=> {calc_cfg.mains_60, calc_cfg.long_refresh} == wd_q[23:22];
	endproperty
	a_m2: assert property (p_m2) else $error("mode two decode wrong");
	property p_m3;
		w_m3 |=> {calc_cfg.isum_vs_sum, calc_cfg.va_vector, calc_cfg.power_algebraic,
			pulse_cfg.gate, pulse_cfg.energy_algebraic, pulse_cfg.react_full,
			pulse_cfg.act_fund} == {wd_q[4], wd_q[7], wd_q[8], wd_q[9], wd_q[15], wd_q[16], wd_q[17]};
	endproperty
	a_m3: assert property (p_m3) else $error("mode three decode wrong");
	property p_unm;
		r_un |=> rd_data == 24'h0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_pdrd;
		bus_req.rd && bus_req.addr == OFS_CHAN_PD |=> rd_data[23:11] == 13'h0;
	endproperty
	a_pdrd: assert property (p_pdrd) else $error("power-down read too wide");
	property p_gate;
		!pulse_cfg.gate |=> !energy_pulse_first && !energy_pulse_second;
	endproperty
	a_gate: assert property (p_gate) else $error("pulse passed while gated");
	property p_pass;
		pulse_cfg.gate && pulse_cfg.kind == MCB_PS_PH_ACT_REACT && energy_raw_first
			|=> energy_pulse_first;
	endproperty
	a_pass: assert property (p_pass) else $error("phase pulse lost");
	property p_app;
		pulse_cfg.kind == MCB_PS_APPARENT |=> !energy_pulse_first;
	endproperty
	a_app: assert property (p_app) else $error("apparent code drove first");
	property p_tick;
		rms_refresh_tick |=> !rms_refresh_tick [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("refresh ticks too close");
	c_m3: cover property (w_m3);
	c_tick: cover property (rms_refresh_tick);
	c_pulse: cover property (energy_pulse_second);
endmodule : mcb_config_bank_properties

bind mcb_config_bank mcb_config_bank_properties #(
	.REFRESH_CYC_SHORT(REFRESH_CYC_SHORT), .REFRESH_CYC_LONG(REFRESH_CYC_LONG)
) u_props (
	.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
	.chan_pd(chan_pd), .rms_src(rms_src), .calc_cfg(calc_cfg), .pulse_cfg(pulse_cfg),
	.rms_refresh_tick(rms_refresh_tick), .energy_raw_first(energy_raw_first),
	.energy_raw_second(energy_raw_second), .energy_pulse_first(energy_pulse_first),
	.energy_pulse_second(energy_pulse_second)
);

//--- verif/mcb_config_bank_bench.sv
// Testbench: register access and decode checks of the metering config bank
`timescale 1ns/100ps
module mcb_config_bank_bench
	import mcb_pkg::*;
();
	localparam int SHORT = 20;
	localparam int LONG  = 40;
	logic           sys_clk, rst, raw1, raw2;
	mcb_bus_req_t   bus_req;
	logic [23:0]    rd_data;
	mcb_chan_pd_t   chan_pd;
	mcb_rms_src_t   rms_src, rs;
	mcb_calc_cfg_t  calc_cfg;
	mcb_pulse_cfg_t pulse_cfg;
	logic           tick, pf1, pf2;
	logic [10:0]    d;
	int             fails, n_checks;
	int             pos [7] = '{10, 9, 8, 5, 4, 3, 2};
	mcb_rms_path_t  paths [3] = '{MCB_RMS_HPF, MCB_RMS_FUND, MCB_RMS_SINC};
	logic [1:0]     codes [3] = '{2'b00, 2'b01, 2'b11};

	mcb_config_bank #(.REFRESH_CYC_SHORT(SHORT), .REFRESH_CYC_LONG(LONG)) dut (
		.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
		.chan_pd(chan_pd), .rms_src(rms_src), .calc_cfg(calc_cfg), .pulse_cfg(pulse_cfg),
		.rms_refresh_tick(tick), .energy_raw_first(raw1), .energy_raw_second(raw2),
		.energy_pulse_first(pf1), .energy_pulse_second(pf2)
	);

	task check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [23:0] v);
		@(posedge sys_clk) bus_req <= '{a, v, 1'b1, 1'b0};
		@(posedge sys_clk) bus_req.wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [23:0] exp);
		@(posedge sys_clk) bus_req <= '{a, 24'h0, 1'b0, 1'b1};
		@(posedge sys_clk) bus_req.rd <= 1'b0;
		#1 check(rd_data, exp);
	endtask : rd
	task tick_gap(input int exp);
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 200) begin
			@(posedge sys_clk) #1 n++;
		end
		n = 0;
		do begin
			@(posedge sys_clk) #1 n++;
		end while (tick !== 1'b1 && n < 200);
		check(n, exp);
	endtask : tick_gap
	task pulse(input logic [3:0] c, input logic g);
		logic live;
		live = g && c != 4'h0 && c != 4'hf;
		wr(OFS_OPERATING_CONFIG_THREE, {10'h0, c, g, 9'h0});
		check(pulse_cfg.kind, (c == 0 || c == 15) ? MCB_PS_OFF : c < 4 ? MCB_PS_PH_ACT_REACT :
			(c == 4 || c == 13) ? MCB_PS_SUM_ACT_REACT : c < 8 ? MCB_PS_PH_POS_QUAD :
			c == 8 ? MCB_PS_SUM_POS_Q4 : c < 12 ? MCB_PS_PH_NEG_APP :
			c == 12 ? MCB_PS_SUM_NEG_APP : MCB_PS_APPARENT);
		check(pulse_cfg.phase, (c[1:0] != 0 && c < 12) ? c[1:0] - 2'd1 : 2'd0);
		@(posedge sys_clk) {raw1, raw2} <= 2'b11;
		@(posedge sys_clk) {raw1, raw2} <= 2'b00;
		#1 check(pf1, live && c != 4'he);
		check(pf2, live);
	endtask : pulse
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Whole sequence is a few hundred cycles
	initial begin
		#100000;
		fails++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		bus_req = '0;
		{raw1, raw2} = 2'b00;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd(OFS_CHAN_PD, 24'h0);
		rd(OFS_OPERATING_CONFIG_ONE, 24'h0);
		rd(OFS_OPERATING_CONFIG_TWO, 24'h0);
		rd(OFS_OPERATING_CONFIG_THREE, 24'h0);
		check(rms_src, 24'h0);
		wr(8'h50, 24'hffffff);
		rd(8'h50, 24'h0);
		tick_gap(SHORT);
		wr(OFS_CHAN_PD, 24'h0000c3);
		rd(OFS_CHAN_PD, 24'h0000c3);
		check(chan_pd, 24'h0);
		for (int i = 0; i < 7; i++) begin
			d = 11'h0c3 | (11'h1 << pos[i]);
			wr(OFS_CHAN_PD, {13'h0, d});
			check(chan_pd, {d[8], d[9], d[10], d[4], d[3], d[2], d[5]});
		end
		wr(OFS_OPERATING_CONFIG_ONE, 24'hffffff);
		rd(OFS_OPERATING_CONFIG_ONE, 24'hc00000);
		check({calc_cfg.wave_fast, calc_cfg.fast_hpf}, 2'b11);
		for (int j = 0; j < 3; j++) begin
			wr(OFS_OPERATING_CONFIG_TWO, 24'h054154 * codes[j]);
			check(rms_src, {7{paths[j]}});
		end
		wr(OFS_OPERATING_CONFIG_TWO, 24'h0c03d0);
		rs = '{ia: MCB_RMS_SINC, ib: MCB_RMS_FUND, in: MCB_RMS_SINC, vc: MCB_RMS_SINC,
			default: MCB_RMS_HPF};
		check(rms_src, rs);
		wr(OFS_OPERATING_CONFIG_TWO, 24'hc00000);
		check({calc_cfg.mains_60, calc_cfg.long_refresh}, 2'b11);
		tick_gap(LONG);
		for (int p = 0; p < 4; p++) begin
			wr(OFS_OPERATING_CONFIG_THREE, 24'(p) << 5);
			check(calc_cfg.period_phase, p == 3 ? 0 : p);
		end
		wr(OFS_OPERATING_CONFIG_THREE, 24'h038390);
		rd(OFS_OPERATING_CONFIG_THREE, 24'h038390);
		check({calc_cfg.isum_vs_sum, calc_cfg.va_vector, calc_cfg.power_algebraic,
			pulse_cfg.energy_algebraic, pulse_cfg.react_full, pulse_cfg.act_fund},
			6'h3f);
		for (int c = 0; c < 16; c++)
			pulse(4'(c), 1'b1);
		pulse(4'h1, 1'b0);
		conclude();
	end
endmodule : mcb_config_bank_bench
